// [pkg/tsf_pkg.sv]
// constants shared by the temperature sample queue and its slope filter
package tsf_pkg;
  localparam int          QDEPTH      = 64;
  localparam int          HIST_DEPTH  = 64;
  // register offsets
  localparam logic [7:0]  OFF_STATUS  = 8'h00;
  localparam logic [7:0]  OFF_IRQ_EN  = 8'h02;
  localparam logic [7:0]  OFF_WR_PTR  = 8'h04;
  localparam logic [7:0]  OFF_RD_PTR  = 8'h05;
  localparam logic [7:0]  OFF_LOST    = 8'h06;
  localparam logic [7:0]  OFF_COUNT   = 8'h07;
  localparam logic [7:0]  OFF_QDATA   = 8'h08;
  localparam logic [7:0]  OFF_WMARK   = 8'h09;
  localparam logic [7:0]  OFF_QCFG    = 8'h0A;
  localparam logic [7:0]  OFF_PINCFG  = 8'h12;
  localparam logic [7:0]  OFF_RISE    = 8'h26;
  localparam logic [7:0]  OFF_FALL    = 8'h27;
  localparam logic [7:0]  OFF_SLOPE   = 8'h28;
  // field positions and values
  localparam int          BIT_AFULL   = 7;
  localparam int          BIT_READY   = 6;
  localparam int          BIT_AF_EN   = 7;
  localparam int          BIT_ROLL    = 1;
  localparam int          BIT_AFTYPE  = 2;
  localparam int          BIT_CLRQRD  = 3;
  localparam int          BIT_FLUSH   = 4;
  localparam int          BIT_CHG_EN  = 3;
  localparam logic [1:0]  LAST_BYTE   = 2'h2;
  localparam logic [5:0]  PTR_MAX     = 6'h3F;
  localparam logic [1:0]  FCFG_ROUTE  = 2'h0;
  localparam logic [1:0]  OCFG_OFF    = 2'h0;
  localparam logic [1:0]  OCFG_OD_LOW = 2'h1;
  localparam logic [2:0]  LEN_CAP     = 3'h6;
  localparam logic [1:0]  RATE_RISE   = 2'h2;
  localparam logic [1:0]  RATE_FALL   = 2'h3;
  localparam logic [1:0]  RATE_NORM   = 2'h0;
  localparam logic [23:0] EMPTY_WORD  = 24'hFF_FFFF;
  // reset values
  localparam logic [5:0]  RST_WMARK   = 6'h00;
  localparam logic [7:0]  RST_LIMIT   = 8'h00;
  localparam logic [3:0]  RST_SLOPE   = 4'h0;
  localparam logic [1:0]  RST_PINCFG  = 2'h0;
endpackage

// [hw/tsf_slope.sv]
// slope filter over the last 2..65 temperature samples
`timescale 1ns/1ps
`default_nettype none
module tsf_slope #(
  parameter int HIST = tsf_pkg::HIST_DEPTH
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic        sample_valid,
  input  wire logic [15:0] sample,
  input  wire logic [2:0]  len_code,
  input  wire logic        enable,
  output logic             slope_ok,
  output logic [8:0]       slope
);
  import tsf_pkg::*;

  typedef struct packed {
    logic [HIST-1:0][15:0] hist;
    logic [6:0]            fill;
    logic [2:0]            len_q;
  } tsf_slope_t;

  tsf_slope_t st;
  tsf_slope_t next_st;
  logic [2:0]  shift;
  logic [6:0]  need;
  logic [16:0] diff;
  logic [16:0] quot;

  always_comb begin
    shift = (len_code >= LEN_CAP) ? LEN_CAP : len_code;
    need  = 7'(7'd1 << shift);
  end

  always_comb begin
    next_st = st;
    diff = 17'({sample[15], sample}) - 17'({st.hist[need - 7'd1][15], st.hist[need - 7'd1]});
    quot = $signed(diff) >>> shift;
    // no slope before span filled
    // a length change empties the window before any result counts
    slope_ok = enable && sample_valid && (st.fill >= need) && (st.len_q == len_code);
    // saturate to the 9-bit signed range
    if (!quot[16] && quot[15:8] != 8'h00) begin
      slope = 9'h0FF;
    end else if (quot[16] && quot[15:8] != 8'hFF) begin
      slope = 9'h100;
    end else begin
      slope = quot[8:0];
    end
    next_st.len_q = len_code;
    if (!enable || len_code != st.len_q) begin
      next_st.fill = 7'h00;
    end else if (sample_valid) begin
      next_st.hist = {st.hist[HIST-2:0], sample};
      if (st.fill < 7'(HIST)) begin
        next_st.fill = st.fill + 7'd1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  AST_NO_EARLY_SLOPE: assert property (@(posedge clk_sys) disable iff (!resetn)
    slope_ok |-> st.fill >= need && st.len_q == len_code)
    else $error("slope reported before the window filled");

  AST_LONG_SPAN: assert property (@(posedge clk_sys) disable iff (!resetn)
    len_code[2:1] == 2'b11 |-> need == 7'd64)
    else $error("codes 6 and 7 must span 65 samples");
endmodule // tsf_slope
`default_nettype wire

// [hw/tsf_queue.sv]
// temperature sample queue with tagging, watermark and register port
//
// Notes on behaviour
// - three-bit length code picks 2,3,5,9,17,33,65 samples; 6 and 7 both 65
// - no slope result until the selected number of samples is collected
// - rise limit is N times 5 m°C per sample, N 0..255
// - fall limit is negative slope, same scale, N 0..255
// - queue of 64 entries, each 16-bit value plus tag
// - entry is tag 23:16 then data; tag 0,source,rate,threshold,1
// - rate field: 0x normal, 10 rise too fast, 11 fall too fast
// - threshold field: 0x normal, 10 below low, 11 above high
// - on rate violation store 9-bit slope with the rate bits
// - six-bit write pointer advances per push, wraps 0x3F to 0x00
// - six-bit read pointer advances per word read, wraps 0x3F to 0x00
// - lost words counted in six bits, saturating at 0x3F
// - lost-word counter cleared whenever a full word is popped
// - seven-bit unread count up on push, down on word read
// - read pointer steps once per completed three-byte burst
// - almost-full flag when count reaches 64 minus watermark
// - interrupt pin only with enable bit and pin routing set
// - when full, rollover overwrites oldest, else new sample dropped
// - type low re-flags every stored sample; high only on new condition
// - clear-on-queue-read low: status read only; high: either read
// - flush bit empties queue and zeroes pointers, count, lost counter
// - address pointer holds at 0x08 so reads drain successive bytes
`timescale 1ns/1ps
`default_nettype none
module tsf_queue #(
  parameter int DEPTH = tsf_pkg::QDEPTH
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic        reg_addr_load,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  input  wire logic        conv_push,
  input  wire logic [15:0] conv_temp,
  input  wire logic [1:0]  conv_source,
  input  wire logic [1:0]  conv_thresh,
  input  wire logic        conv_enabled,
  output logic             irq_out,
  output logic             irq_oe
);
  import tsf_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][23:0] mem;
    logic [5:0]             wr_ptr;
    logic [5:0]             rd_ptr;
    logic [5:0]             lost;
    logic [6:0]             cnt;
    logic [1:0]             byte_idx;
    logic [7:0]             addr;
    logic [7:0]             rdata;
    logic                   a_full;
    logic                   ready;
    logic                   a_cond;
    logic [5:0]             wmark;
    logic                   roll;
    logic                   af_type;
    logic                   clr_qrd;
    logic                   af_en;
    logic [1:0]             ocfg;
    logic [1:0]             fcfg;
    logic [7:0]             rise;
    logic [7:0]             fall;
    logic [3:0]             slope_cfg;
    logic                   irq_out;
    logic                   irq_oe;
  } tsf_state_t;

  tsf_state_t  st;
  tsf_state_t  next_st;
  logic        slope_ok;
  logic [8:0]  slope;
  logic [1:0]  rate;
  logic [23:0] word_in;
  logic [23:0] word_out;
  logic [7:0]  rd_mux;
  logic [6:0]  cnt_mid;
  logic        full;
  logic        qrd;
  logic        srd;
  logic        pop_word;
  logic        push_acc;
  logic        push_roll;
  logic        flush;
  logic        irq_want;

  tsf_slope u_slope (
    .clk_sys      (clk_sys),
    .resetn       (resetn),
    .ce           (ce),
    .sample_valid (conv_push),
    .sample       (conv_temp),
    .len_code     (st.slope_cfg[2:0]),
    .enable       (st.slope_cfg[BIT_CHG_EN] && conv_enabled),
    .slope_ok     (slope_ok),
    .slope        (slope)
  );

  // tag and payload for the incoming sample
  always_comb begin
    rate = RATE_NORM;
    // rise beyond N LSB per sample
    if (slope_ok && !slope[8] && slope[7:0] > st.rise) begin
      rate = RATE_RISE;
    end
    // fall beyond N LSB per sample
    if (slope_ok && slope[8] && $signed(slope) < -$signed({1'b0, st.fall})) begin
      rate = RATE_FALL;
    end
    // tag layout, rate code, threshold code
    word_in[23:16] = {1'b0, conv_source, rate, conv_thresh, 1'b1};
    // slope replaces the value on a violation
    word_in[15:0] = rate[1] ? {{7{slope[8]}}, slope} : conv_temp;
  end

  // read data mux, byte of the current entry picked by burst position
  always_comb begin
    word_out = (st.cnt == 7'h00) ? EMPTY_WORD : st.mem[st.rd_ptr];
    case (st.addr)
      OFF_STATUS: rd_mux = {st.a_full, st.ready, 6'h00};
      OFF_IRQ_EN: rd_mux = {st.af_en, 7'h00};
      OFF_WR_PTR: rd_mux = {2'h0, st.wr_ptr};
      OFF_RD_PTR: rd_mux = {2'h0, st.rd_ptr};
      OFF_LOST:   rd_mux = {2'h0, st.lost};
      OFF_COUNT:  rd_mux = {1'b0, st.cnt};
      OFF_QDATA: begin
        case (st.byte_idx)
          2'h0:    rd_mux = word_out[23:16];
          2'h1:    rd_mux = word_out[15:8];
          default: rd_mux = word_out[7:0];
        endcase
      end
      OFF_WMARK:  rd_mux = {2'h0, st.wmark};
      OFF_QCFG:   rd_mux = {4'h0, st.clr_qrd, st.af_type, st.roll, 1'b0};
      OFF_PINCFG: rd_mux = {4'h0, st.fcfg, st.ocfg};
      OFF_RISE:   rd_mux = st.rise;
      OFF_FALL:   rd_mux = st.fall;
      OFF_SLOPE:  rd_mux = {4'h0, st.slope_cfg};
      default:    rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    next_st   = st;
    qrd       = 1'b0;
    srd       = 1'b0;
    pop_word  = 1'b0;
    push_acc  = 1'b0;
    push_roll = 1'b0;
    flush     = 1'b0;
    full      = 1'b0;
    cnt_mid   = st.cnt;
    irq_want  = 1'b0;

    // register reads
    if (reg_rd) begin
      next_st.rdata = rd_mux;
      srd = (st.addr == OFF_STATUS);
      if (st.addr == OFF_QDATA) begin
        qrd = 1'b1;
        if (st.byte_idx == LAST_BYTE) begin
          next_st.byte_idx = 2'h0;
          pop_word = (st.cnt != 7'h00);
        end else begin
          next_st.byte_idx = st.byte_idx + 2'h1;
        end
      end else begin
        next_st.addr = st.addr + 8'h01;
      end
    end

    // register writes; the queue port itself takes no data
    if (reg_wr) begin
      case (st.addr)
        OFF_IRQ_EN: next_st.af_en = reg_wdata[BIT_AF_EN];
        OFF_WR_PTR: next_st.wr_ptr = reg_wdata[5:0];
        OFF_RD_PTR: next_st.rd_ptr = reg_wdata[5:0];
        OFF_WMARK:  next_st.wmark = reg_wdata[5:0];
        OFF_QCFG: begin
          next_st.roll    = reg_wdata[BIT_ROLL];
          next_st.af_type = reg_wdata[BIT_AFTYPE];
          next_st.clr_qrd = reg_wdata[BIT_CLRQRD];
          flush           = reg_wdata[BIT_FLUSH];
        end
        OFF_PINCFG: begin
          next_st.ocfg = reg_wdata[1:0];
          next_st.fcfg = reg_wdata[3:2];
        end
        OFF_RISE:   next_st.rise = reg_wdata;
        OFF_FALL:   next_st.fall = reg_wdata;
        OFF_SLOPE:  next_st.slope_cfg = reg_wdata[3:0];
        default:    next_st.addr = next_st.addr;
      endcase
      // no auto-increment on the queue port
      if (st.addr != OFF_QDATA) begin
        next_st.addr = st.addr + 8'h01;
      end
    end

    // a new frame resets the burst position
    if (reg_addr_load) begin
      next_st.addr     = reg_addr;
      next_st.byte_idx = 2'h0;
    end

    // read pointer wraps naturally in six bits
    if (pop_word) begin
      next_st.rd_ptr = next_st.rd_ptr + 6'h01;
      cnt_mid = st.cnt - 7'd1;
      // popped word clears the lost count
      next_st.lost = 6'h00;
    end
    next_st.cnt = cnt_mid;

    // clears come first so a same-cycle set wins
    if (srd || (qrd && st.clr_qrd)) begin
      next_st.a_full = 1'b0;
      next_st.ready  = 1'b0;
    end

    if (conv_push) begin
      full = (cnt_mid == 7'(DEPTH));
      if (!full) begin
        next_st.mem[st.wr_ptr] = word_in;
        // write pointer wraps in six bits
        next_st.wr_ptr = st.wr_ptr + 6'h01;
        next_st.cnt = cnt_mid + 7'd1;
        push_acc = 1'b1;
      end else begin
        if (st.roll) begin
          next_st.mem[st.wr_ptr] = word_in;
          next_st.wr_ptr = st.wr_ptr + 6'h01;
          next_st.rd_ptr = next_st.rd_ptr + 6'h01;
          push_roll = 1'b1;
        end
        if (st.lost != PTR_MAX) begin
          next_st.lost = st.lost + 6'h01;
        end
      end
    end

    next_st.a_cond = (next_st.cnt >= 7'(DEPTH) - {1'b0, st.wmark});
    if (push_acc || push_roll) begin
      next_st.ready = 1'b1;
      if (next_st.a_cond && (!st.af_type || !st.a_cond)) begin
        next_st.a_full = 1'b1;
      end
    end

    if (flush) begin
      next_st.wr_ptr   = 6'h00;
      next_st.rd_ptr   = 6'h00;
      next_st.cnt      = 7'h00;
      next_st.lost     = 6'h00;
      next_st.byte_idx = 2'h0;
      next_st.a_cond   = 1'b0;
    end

    // pin asserted only when enabled and routed
    irq_want = st.a_full && st.af_en && st.fcfg == FCFG_ROUTE;
    if (st.ocfg == OCFG_OFF) begin
      next_st.irq_oe  = 1'b0;
      next_st.irq_out = 1'b0;
    end else if (st.ocfg == OCFG_OD_LOW) begin
      // open drain: only pull low while asserted
      next_st.irq_oe  = irq_want;
      next_st.irq_out = 1'b0;
    end else begin
      next_st.irq_oe  = 1'b1;
      next_st.irq_out = irq_want;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st           <= '0;
      st.wmark     <= RST_WMARK;
      st.rise      <= RST_LIMIT;
      st.fall      <= RST_LIMIT;
      st.slope_cfg <= RST_SLOPE;
      st.ocfg      <= RST_PINCFG;
      st.fcfg      <= RST_PINCFG;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign irq_out   = st.irq_out;
  assign irq_oe    = st.irq_oe;

  AST_WR_WRAP: assert property (@(posedge clk_sys) disable iff (!resetn)
    ce && push_acc && !flush && !reg_wr && st.wr_ptr == PTR_MAX |=> st.wr_ptr == 6'h00)
    else $error("write pointer did not wrap to zero");

  AST_POP_STEP: assert property (@(posedge clk_sys) disable iff (!resetn)
    ce && pop_word && !push_roll && !flush && !reg_wr
    |=> st.rd_ptr == $past(st.rd_ptr) + 6'h01 && st.lost == 6'h00)
    else $error("word pop did not step the read pointer and clear lost count");

  AST_LOST_SAT: assert property (@(posedge clk_sys) disable iff (!resetn)
    ce && st.lost == PTR_MAX && conv_push && full && !pop_word && !flush
    |=> st.lost == PTR_MAX)
    else $error("lost-word counter left saturation");

  AST_DROP: assert property (@(posedge clk_sys) disable iff (!resetn)
    ce && full && !st.roll && !reg_wr |=> st.wr_ptr == $past(st.wr_ptr)
    && st.mem == $past(st.mem))
    else $error("full queue without rollover changed");

  AST_TAG: assert property (@(posedge clk_sys) disable iff (!resetn)
    ce && push_acc |=> st.mem[$past(st.wr_ptr)][23] == 1'b0
    && st.mem[$past(st.wr_ptr)][16] == 1'b1)
    else $error("stored tag lacks its fixed bits");

  AST_AFULL: assert property (@(posedge clk_sys) disable iff (!resetn)
    ce && push_acc && !st.af_type && !flush
    && next_st.cnt >= 7'(DEPTH) - {1'b0, st.wmark} |=> st.a_full)
    else $error("almost-full flag missed at watermark");

  AST_ADDR_HOLD: assert property (@(posedge clk_sys) disable iff (!resetn)
    ce && reg_rd && !reg_addr_load && st.addr == OFF_QDATA |=> st.addr == OFF_QDATA)
    else $error("address moved off the queue port");

  AST_FLUSH: assert property (@(posedge clk_sys) disable iff (!resetn)
    ce && flush |=> st.cnt == 7'h00 && st.wr_ptr == 6'h00 && st.rd_ptr == 6'h00
    && st.lost == 6'h00)
    else $error("flush left queue state behind");

  AST_IRQ_GATE: assert property (@(posedge clk_sys) disable iff (!resetn)
    ce && !st.af_en && st.ocfg == OCFG_OD_LOW |=> !st.irq_oe)
    else $error("interrupt pulled without enable");

  AST_STAT_CLR: assert property (@(posedge clk_sys) disable iff (!resetn)
    ce && srd && !conv_push |=> !st.a_full && !st.ready)
    else $error("status read did not clear flags");
endmodule // tsf_queue
`default_nettype wire

// [bench/tsf_host.sv]
// host-side model issuing register accesses to the sample queue
`timescale 1ns/1ps
`default_nettype none
module tsf_host (
  input  wire logic       clk_sys,
  output logic            reg_addr_load,
  output logic [7:0]      reg_addr,
  output logic            reg_wr,
  output logic [7:0]      reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  import tsf_pkg::*;
  initial begin
    reg_addr_load = 1'b0;
    reg_addr      = 8'h00;
    reg_wr        = 1'b0;
    reg_wdata     = 8'h00;
    reg_rd        = 1'b0;
  end
  // released lines show the inverse so stale values are never trusted
  task automatic point(input logic [7:0] a);
    @(posedge clk_sys) #1;
    reg_addr_load = 1'b1;
    reg_addr      = a;
    @(posedge clk_sys) #1;
    reg_addr_load = 1'b0;
    reg_addr      = ~a;
  endtask
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    point(a);
    @(posedge clk_sys) #1;
    reg_wr    = 1'b1;
    reg_wdata = d;
    @(posedge clk_sys) #1;
    reg_wr    = 1'b0;
    reg_wdata = ~d;
  endtask
  // data is registered, so it is taken one edge after the strobe
  task automatic take(output logic [7:0] d);
    @(posedge clk_sys) #1;
    reg_rd = 1'b1;
    @(posedge clk_sys) #1;
    reg_rd = 1'b0;
    d      = reg_rdata;
  endtask
  task automatic get(input logic [7:0] a, output logic [7:0] d);
    point(a);
    take(d);
  endtask
  // one sample is three reads at the data port
  task automatic word(output logic [23:0] w);
    point(OFF_QDATA);
    take(w[23:16]);
    take(w[15:8]);
    take(w[7:0]);
  endtask
endmodule // tsf_host
`default_nettype wire

// [bench/testbench.sv]
// self-checking bench for the temperature sample queue
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tsf_pkg::*;
  logic        clk_sys;
  logic        resetn;
  logic        reg_addr_load;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic [7:0]  reg_wdata;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        conv_push;
  logic [15:0] conv_temp;
  logic [1:0]  conv_source;
  logic [1:0]  conv_thresh;
  logic        irq_out;
  logic        irq_oe;
  int          num_errors;
  int          n_compared;
  logic        conv_en;

  tsf_queue i_dut (.clk_sys(clk_sys), .resetn(resetn), .ce(1'b1),
    .reg_addr_load(reg_addr_load), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .conv_push(conv_push), .conv_temp(conv_temp), .conv_source(conv_source),
    .conv_thresh(conv_thresh), .conv_enabled(conv_en), .irq_out(irq_out),
    .irq_oe(irq_oe));
  tsf_host i_host (.clk_sys(clk_sys), .reg_addr_load(reg_addr_load),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic push(input logic [15:0] t, input logic [1:0] s, input logic [1:0] th);
    @(posedge clk_sys) #1;
    conv_push   = 1'b1;
    conv_temp   = t;
    conv_source = s;
    conv_thresh = th;
    @(posedge clk_sys) #1;
    conv_push   = 1'b0;
    conv_temp   = ~t;
  endtask
  task automatic reg_is(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_host.get(a, d);
    check({24'h0, d}, {24'h0, exp});
  endtask
  task automatic word_is(input logic [23:0] exp);
    logic [23:0] d;
    i_host.word(d);
    check({8'h0, d}, {8'h0, exp});
  endtask

  // empty queue after reset, unmapped place reads zero
  task automatic s_reset();
    reg_is(OFF_WR_PTR, 8'h00);
    reg_is(OFF_COUNT, 8'h00);
    reg_is(8'h50, 8'h00);
    word_is(EMPTY_WORD);
    reg_is(OFF_RD_PTR, 8'h00);
  endtask
  // every source and the threshold codes 00, 10 and 11 land in the tag
  task automatic s_tags();
    logic [1:0] th[3] = '{2'b00, 2'b10, 2'b11};
    for (int s = 0; s < 4; s++) begin
      for (int k = 0; k < 3; k++) begin
        push(16'hA5C0 + 16'(s * 3 + k), 2'(s), th[k]);
        word_is({1'b0, 2'(s), RATE_NORM, th[k], 1'b1, 16'hA5C0 + 16'(s * 3 + k)});
      end
    end
    reg_is(OFF_RD_PTR, 8'h0C);
    reg_is(OFF_COUNT, 8'h00);
  endtask
  // rate flags from the shortest and the longest slope window
  task automatic s_slope();
    conv_en = 1'b1;
    i_host.put(OFF_RISE, 8'h01);
    i_host.put(OFF_SLOPE, 8'h08);
    push(16'h0100, 2'b01, 2'b00);
    push(16'h0130, 2'b01, 2'b00);
    push(16'h0100, 2'b01, 2'b00);
    word_is({8'h21, 16'h0100});
    word_is({8'h31, 16'h0030});
    word_is({8'h39, 16'hFFD0});
    i_host.put(OFF_SLOPE, 8'h0F);
    for (int i = 0; i < 63; i++) push(16'(i * 128), 2'b01, 2'b00);
    i_host.put(OFF_QCFG, 8'h10);
    push(16'h1F80, 2'b01, 2'b00);
    push(16'h2000, 2'b01, 2'b00);
    word_is({8'h21, 16'h1F80});
    word_is({8'h31, 16'h0080});
    conv_en = 1'b0;
  endtask
  // fill past full, watermark, interrupt pin, rollover and status clearing
  task automatic s_full();
    i_host.put(OFF_QCFG, 8'h10);
    reg_is(OFF_WR_PTR, 8'h00);
    reg_is(OFF_RD_PTR, 8'h00);
    reg_is(OFF_QCFG, 8'h00);
    i_host.put(OFF_WMARK, 8'h02);
    i_host.put(OFF_IRQ_EN, 8'h80);
    i_host.put(OFF_PINCFG, 8'h02);
    for (int i = 0; i < 61; i++) push(16'(i), 2'b01, 2'b00);
    reg_is(OFF_STATUS, 8'h40);
    check({31'h0, irq_out}, 32'h0);
    push(16'd61, 2'b01, 2'b00);
    repeat (3) @(posedge clk_sys);
    #1 check({30'h0, irq_oe, irq_out}, 32'h3);
    i_host.put(OFF_PINCFG, 8'h01);
    @(posedge clk_sys) #1 check({30'h0, irq_oe, irq_out}, 32'h2);
    i_host.put(OFF_IRQ_EN, 8'h00);
    @(posedge clk_sys) #1 check({30'h0, irq_oe, irq_out}, 32'h0);
    reg_is(OFF_STATUS, 8'hC0);
    for (int i = 62; i < 66; i++) push(16'(i), 2'b01, 2'b00);
    reg_is(OFF_LOST, 8'h02);
    reg_is(OFF_COUNT, 8'h40);
    reg_is(OFF_WR_PTR, 8'h00);
    word_is({8'h21, 16'h0000});
    reg_is(OFF_LOST, 8'h00);
    reg_is(OFF_STATUS, 8'hC0);
    i_host.put(OFF_QCFG, 8'h02);
    push(16'h0040, 2'b01, 2'b00);
    push(16'h0041, 2'b01, 2'b00);
    reg_is(OFF_COUNT, 8'h40);
    word_is({8'h21, 16'h0002});
    reg_is(OFF_COUNT, 8'h3F);
    i_host.put(OFF_QCFG, 8'h0A);
    push(16'h0042, 2'b01, 2'b00);
    word_is({8'h21, 16'h0003});
    reg_is(OFF_STATUS, 8'h00);
    i_host.put(OFF_QCFG, 8'h04);
    push(16'h0043, 2'b01, 2'b00);
    reg_is(OFF_STATUS, 8'h40);
  endtask

  initial begin
    resetn      = 1'b0;
    conv_push   = 1'b0;
    conv_temp   = 16'h0000;
    conv_source = 2'b00;
    conv_thresh = 2'b00;
    conv_en     = 1'b0;
    num_errors  = 0;
    n_compared  = 0;
    repeat (12) @(posedge clk_sys);
    #1 resetn = 1'b1;
    s_reset();
    s_tags();
    s_slope();
    s_full();
    report_and_stop();
  end

  // hang guard, far beyond the length of the sequence
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
